// ---- common/bufcfg_pkg.sv ----
// constants and types for the sample buffer flush and watermark control
// assumes a byte-wide internal register port on one 50 MHz clock
package bufcfg_pkg;
    localparam logic [7:0] CFG_TWO_ADDR  = 8'h27;
    localparam logic [7:0] CFG_TWO_RESET = 8'h00;
    localparam int         FLUSH_BIT     = 7;
    localparam int         HOLDOFF_BIT   = 6;
    localparam int         WMRK_MSB      = 5;
    localparam int         CNT_W         = 6;
    localparam logic [5:0] BUF_DEPTH     = 6'h20;
    localparam logic [1:0] MODE_OFF      = 2'h0;
    localparam logic [1:0] MODE_STREAM   = 2'h1;
    localparam logic [1:0] MODE_STOP     = 2'h2;
    localparam logic [1:0] MODE_TRIG     = 2'h3;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;
endpackage : bufcfg_pkg

// ---- hdl/sample_buffer_flush_watermark_ctrl.sv ----
// buffer_config_two register, flush, watermark and sleep holdoff control
// assumes the serial port decoder gives one-cycle write and read strobes
`timescale 1ns/1ps
module sample_buffer_flush_watermark_ctrl
    import bufcfg_pkg::*;
(
    input  wire logic       clk,           // 50 MHz internal clock
    input  wire logic       resetn,        // sync reset, active low
    input  wire reg_req_t   req,           // register access strobe
    output logic [7:0]      rdata,         // register read data
    input  wire logic [1:0] buf_mode,      // buffer mode from config one
    input  wire logic       sample_push,   // new sample pulse
    input  wire logic       sample_pop,    // host read one sample
    input  wire logic       triggered,     // trigger seen in triggered mode
    input  wire logic       aslp_expired,  // auto-sleep timer expiry pulse
    output logic [5:0]      sample_cnt,    // stored sample count
    output logic            wmrk_flag,     // watermark flag
    output logic            overflow_flag, // overflow flag
    output logic            flush_pulse,   // flush strobe to buffer memory
    output logic            gate_clr,      // clear gate error and counter
    output logic            aslp_restart,  // restart auto-sleep timer
    output logic            sleep_req      // go to sleep request
);
    logic       flush_ff;
    logic       holdoff_ff;
    logic [5:0] wmrk_ff;
    logic [5:0] cnt_ff;
    logic       ovf_ff;
    logic [7:0] rdata_ff;

    // true once a count has reached a level
    function automatic logic reached(input logic [5:0] cnt,
                                     input logic [5:0] lvl);
        return cnt >= lvl;
    endfunction : reached

    // register decode
    wire cfg_hit  = req.addr == CFG_TWO_ADDR;
    wire cfg_wr   = req.wr && cfg_hit;
    wire rd_hit   = req.rd && cfg_hit;
    wire do_flush = cfg_wr && req.wdata[FLUSH_BIT];
    wire off      = buf_mode == MODE_OFF;
    wire clr_all  = flush_ff || off;
    wire holdoff_mode = buf_mode == MODE_STREAM || buf_mode == MODE_STOP;
    // pre-trigger limit is a nonzero watermark in triggered mode, else the buffer depth
    wire [5:0] limit = (buf_mode == MODE_TRIG && !triggered && wmrk_ff != 0)
                       ? wmrk_ff : BUF_DEPTH;
    wire full     = reached(cnt_ff, limit);
    wire pretrig  = buf_mode == MODE_TRIG && !triggered;
    // stream-like: drop oldest while pre-trigger full
    wire push_ok  = sample_push && (!full || pretrig);
    wire pop_ok   = sample_pop && cnt_ff != 0;
    wire [5:0] nxt_cnt = (push_ok && !full && !pop_ok)
                             ? cnt_ff + 6'h01
                       : (pop_ok && !push_ok) ? cnt_ff - 6'h01
                       : cnt_ff;
    wire flags_on  = wmrk_flag || overflow_flag;
    wire flags_clr = (flush_ff || pop_ok) && flags_on;

    // config register: flush self-clears next cycle
    always_ff @(posedge clk) begin
        if (!resetn) begin
            flush_ff   <= CFG_TWO_RESET[FLUSH_BIT];
            holdoff_ff <= CFG_TWO_RESET[HOLDOFF_BIT];
            wmrk_ff    <= CFG_TWO_RESET[WMRK_MSB:0];
        end else begin
            flush_ff <= do_flush;
            if (cfg_wr) begin
                holdoff_ff <= req.wdata[HOLDOFF_BIT];
                wmrk_ff    <= req.wdata[WMRK_MSB:0];
            end
        end
    end

    // sample count and overflow bookkeeping
    always_ff @(posedge clk) begin
        if (!resetn || clr_all) begin
            cnt_ff <= 6'h00;
            ovf_ff <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            if (sample_push && full && !pretrig)
                ovf_ff <= 1'b1;
            else if (pop_ok)
                ovf_ff <= 1'b0;
        end
    end

    // read data registered; flush bit always reads zero
    always_ff @(posedge clk) begin
        if (!resetn) begin
            rdata_ff <= 8'h00;
        end else if (rd_hit) begin
            rdata_ff <= {1'b0, holdoff_ff, wmrk_ff};
        end else if (req.rd) begin
            rdata_ff <= 8'h00;
        end
    end

    // watermark compare, zero disables
    assign wmrk_flag     = wmrk_ff != 6'h00
                           && reached(cnt_ff, wmrk_ff);
    assign overflow_flag = ovf_ff;
    assign sample_cnt    = cnt_ff;
    assign rdata         = rdata_ff;
    assign flush_pulse   = flush_ff;
    assign gate_clr      = flush_ff || off;
    // sleep decision with optional flag holdoff
    wire use_flags = holdoff_ff && holdoff_mode;
    assign aslp_restart = use_flags && flags_clr;
    assign sleep_req = aslp_expired && !aslp_restart
                       && (!use_flags || flags_on);

    // flush bit lasts one cycle unless written again
    a_flush_self: assert property (@(posedge clk)
        disable iff (!resetn) flush_ff |=> !flush_ff || $past(do_flush))
        else $error("flush bit did not clear");

    // flush empties the count and overflow
    a_flush_clear: assert property (@(posedge clk)
        disable iff (!resetn) flush_ff |=> cnt_ff == 6'h00 && !ovf_ff)
        else $error("flush did not clear buffer");

    // the flush bit never reads back high
    a_flush_read: assert property (@(posedge clk)
        disable iff (!resetn) req.rd |=> !rdata[FLUSH_BIT])
        else $error("flush bit read high");

    // zero level keeps the watermark flag low
    a_wmrk_zero: assert property (@(posedge clk)
        disable iff (!resetn) wmrk_ff == 6'h00 |-> !wmrk_flag)
        else $error("watermark flag with zero level");

    // count at or above the level raises the flag
    a_wmrk_cmp: assert property (@(posedge clk)
        disable iff (!resetn)
        (wmrk_ff != 6'h00 && cnt_ff >= wmrk_ff) |-> wmrk_flag)
        else $error("watermark flag missing");

    // mode off empties count and overflow
    a_off_clear: assert property (@(posedge clk)
        disable iff (!resetn) off |=> cnt_ff == 6'h00 && !overflow_flag)
        else $error("disable did not clear");

    // flags ignored while holdoff is not in use
    a_hold_ignore: assert property (@(posedge clk)
        disable iff (!resetn) (aslp_expired && !use_flags) |-> sleep_req)
        else $error("flags held off sleep while ignored");

    // holdoff in use without flags keeps the device awake
    a_hold_use: assert property (@(posedge clk)
        disable iff (!resetn)
        (aslp_expired && use_flags && !flags_on) |-> !sleep_req)
        else $error("slept without holdoff flags");

    // any write to the register loads the watermark
    a_hold_write: assert property (@(posedge clk)
        disable iff (!resetn)
        cfg_wr |=> wmrk_ff == $past(req.wdata[WMRK_MSB:0]))
        else $error("watermark not updated on write");

    // flush write loads the holdoff bit as well
    a_hold_bit: assert property (@(posedge clk)
        disable iff (!resetn)
        do_flush |=> holdoff_ff == $past(req.wdata[HOLDOFF_BIT]))
        else $error("holdoff not updated on flush write");

    // a flush write raises the flush bit next cycle
    a_flush_wr: assert property (@(posedge clk)
        disable iff (!resetn) do_flush |=> flush_ff)
        else $error("flush write not taken");

    // gate bookkeeping is cleared on flush
    a_gate_flush: assert property (@(posedge clk)
        disable iff (!resetn) flush_ff |-> gate_clr)
        else $error("gate not cleared on flush");

    // gate bookkeeping is cleared while the buffer is off
    a_gate_off: assert property (@(posedge clk)
        disable iff (!resetn) off |-> gate_clr)
        else $error("gate not cleared while off");

    // read of this register returns holdoff and watermark
    a_rd_value: assert property (@(posedge clk)
        disable iff (!resetn)
        rd_hit |=> rdata == {1'b0, $past(holdoff_ff), $past(wmrk_ff)})
        else $error("register read value wrong");

    // writes to other addresses leave the register alone
    a_wr_other: assert property (@(posedge clk)
        disable iff (!resetn)
        (req.wr && !cfg_hit) |=> wmrk_ff == $past(wmrk_ff)
            && holdoff_ff == $past(holdoff_ff))
        else $error("foreign write changed register");

    // host clearing the flags restarts the timer
    a_restart_pop: assert property (@(posedge clk)
        disable iff (!resetn)
        (use_flags && pop_ok && flags_on) |-> aslp_restart)
        else $error("timer not restarted on flag clear");

    // a restart always keeps the device awake
    a_restart_wake: assert property (@(posedge clk)
        disable iff (!resetn) aslp_restart |-> !sleep_req)
        else $error("slept despite timer restart");

    // uncleared flags let the timer expiry put it to sleep
    a_sleep_flags: assert property (@(posedge clk)
        disable iff (!resetn)
        (aslp_expired && use_flags && flags_on && !flags_clr)
            |-> sleep_req)
        else $error("no sleep with flags uncleared");

    // holdoff only counts in stream or stop mode
    a_mode_gate: assert property (@(posedge clk)
        disable iff (!resetn) !holdoff_mode |-> !use_flags)
        else $error("holdoff used outside stream or stop");

    // pre-trigger count stops at the watermark
    a_pretrig_hold: assert property (@(posedge clk)
        disable iff (!resetn)
        (pretrig && wmrk_ff != 6'h00 && cnt_ff >= wmrk_ff
            && sample_push && !sample_pop && !clr_all)
            |=> cnt_ff == $past(cnt_ff))
        else $error("pre-trigger count passed watermark");

    // pre-trigger gathering never raises overflow
    a_pretrig_ovf: assert property (@(posedge clk)
        disable iff (!resetn)
        (pretrig && !clr_all) |=> !ovf_ff || $past(ovf_ff))
        else $error("overflow set before trigger");

    // a sample accepted below the limit with no pop adds exactly one to the count
    a_cnt_step: assert property (@(posedge clk)
        disable iff (!resetn)
        (push_ok && !full && !pop_ok && !clr_all)
            |=> cnt_ff == $past(cnt_ff) + 6'h01)
        else $error("count did not step");
endmodule : sample_buffer_flush_watermark_ctrl

// ---- testbench/bufcfg_host.sv ----
// host model driving the register port with one-cycle strobes
// assumes strobes are sampled on the rising clock edge
`timescale 1ns/1ps
module bufcfg_host
    import bufcfg_pkg::*;
(
    input  wire logic clk, // internal clock
    output reg_req_t  req  // register access strobe
);
    initial req = '0;
    // one access, held for exactly one edge, then idle
    task automatic acc(input logic w, input logic [7:0] a, d);
        @(posedge clk);
        req <= '{wr: w, rd: !w, addr: a, wdata: d};
        @(posedge clk);
        req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask : acc
endmodule : bufcfg_host

// ---- testbench/sample_buffer_flush_watermark_ctrl_tb.sv ----
// self-checking bench for the flush and watermark control
// assumes bufcfg_host drives the register port
`timescale 1ns/1ps
module sample_buffer_flush_watermark_ctrl_tb
    import bufcfg_pkg::*;
;
    logic clk = 0, resetn = 0, sample_push = 0, sample_pop = 0;
    logic aslp_expired = 0, rd_seen = 0, wmrk_flag, flush_pulse;
    logic gate_clr, sleep_req, overflow_flag, aslp_restart, triggered = 0;
    logic [1:0] buf_mode = MODE_OFF;
    logic [7:0] rdata, exp_q[$];
    logic [5:0] sample_cnt, w;
    reg_req_t   req;
    int fail_count = 0, checks_done = 0;
    always #10 clk = ~clk;
    bufcfg_host i_bufcfg_host (.clk(clk), .req(req));
    sample_buffer_flush_watermark_ctrl i_sample_buffer_flush_watermark_ctrl (
        .clk(clk), .resetn(resetn), .req(req), .rdata(rdata),
        .buf_mode(buf_mode), .sample_push(sample_push),
        .sample_pop(sample_pop), .triggered(triggered),
        .aslp_expired(aslp_expired), .sample_cnt(sample_cnt),
        .wmrk_flag(wmrk_flag), .overflow_flag(overflow_flag),
        .flush_pulse(flush_pulse), .gate_clr(gate_clr),
        .aslp_restart(aslp_restart), .sleep_req(sleep_req));
    task automatic cmp8(input logic [7:0] g, e);
        checks_done++;
        if (g !== e) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : cmp8
    task automatic cmp1(input logic g, e);
        cmp8({7'h00, g}, {7'h00, e});
    endtask : cmp1
    task automatic rd(input logic [7:0] a, e);
        exp_q.push_back(e);
        i_bufcfg_host.acc(1'b0, a, 8'h00);
    endtask : rd
    // one sample pushed or popped, checked after the edge
    task automatic smp(input logic p);
        @(posedge clk);
        sample_push <= p;
        sample_pop <= !p;
        @(posedge clk);
        sample_push <= 1'b0;
        sample_pop <= 1'b0;
        #1;
    endtask : smp
    // timer expiry pulse with the sleep request sampled 1 ns after it rises
    task automatic nap(input logic e);
        @(posedge clk);
        aslp_expired <= 1'b1;
        #1 cmp1(sleep_req, e);
        @(posedge clk);
        aslp_expired <= 1'b0;
    endtask : nap
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : tally_and_finish
    // read data lands one cycle after the strobe
    always @(posedge clk) begin
        if (rd_seen) cmp8(rdata, exp_q.pop_front());
        rd_seen <= req.rd;
    end
    // hang guard
    initial begin
        #100us fail_count++;
        tally_and_finish();
    end
    // main sequence
    initial begin
        void'($urandom(32'hd126));
        w = 6'($urandom % 31) + 6'h01;
        repeat (16) @(posedge clk);
        resetn <= 1'b1;
        rd(CFG_TWO_ADDR, CFG_TWO_RESET);
        i_bufcfg_host.acc(1'b1, CFG_TWO_ADDR, {2'b01, w});
        rd(CFG_TWO_ADDR, {2'b01, w});
        rd(8'h26, 8'h00);
        buf_mode <= MODE_STREAM;
        repeat (int'(w) - 1) smp(1'b1);
        cmp1(wmrk_flag, 1'b0);
        smp(1'b1);
        cmp1(wmrk_flag, 1'b1);
        nap(1'b1);
        smp(1'b0);
        cmp1(wmrk_flag, 1'b0);
        i_bufcfg_host.acc(1'b1, CFG_TWO_ADDR, {2'b11, w});
        #1 cmp1(flush_pulse, 1'b1);
        cmp1(gate_clr, 1'b1);
        @(posedge clk);
        #1 cmp1(flush_pulse, 1'b0);
        cmp8({2'b00, sample_cnt}, 8'h00);
        rd(CFG_TWO_ADDR, {2'b01, w});
        rd(CFG_TWO_ADDR, {2'b01, w});
        nap(1'b0);
        buf_mode <= MODE_TRIG;
        nap(1'b1);
        i_bufcfg_host.acc(1'b1, CFG_TWO_ADDR, 8'h00);
        buf_mode <= MODE_STREAM;
        smp(1'b1);
        cmp1(wmrk_flag, 1'b0);
        nap(1'b1);
        buf_mode <= MODE_OFF;
        @(posedge clk);
        #1 cmp8({2'b00, sample_cnt}, 8'h00);
        // stream overflow, then a pop clears it and restarts the timer
        i_bufcfg_host.acc(1'b1, CFG_TWO_ADDR, {2'b01, w});
        buf_mode <= MODE_STREAM;
        repeat (33) smp(1'b1);
        cmp8({2'b00, sample_cnt}, {2'b00, BUF_DEPTH});
        cmp1(overflow_flag, 1'b1);
        nap(1'b1);
        @(posedge clk);
        sample_pop <= 1'b1;
        #1 cmp1(aslp_restart, 1'b1);
        @(posedge clk);
        sample_pop <= 1'b0;
        #1 cmp1(overflow_flag, 1'b0);
        // pre-trigger gathering stops at the watermark, then fills up
        i_bufcfg_host.acc(1'b1, CFG_TWO_ADDR, {2'b10, w});
        buf_mode <= MODE_TRIG;
        repeat (int'(w) + 2) smp(1'b1);
        cmp8({2'b00, sample_cnt}, {2'b00, w});
        cmp1(overflow_flag, 1'b0);
        @(posedge clk);
        triggered <= 1'b1;
        repeat (33) smp(1'b1);
        cmp1(overflow_flag, 1'b1);
        // reset in mid-run brings back the reset value
        @(posedge clk);
        resetn <= 1'b0;
        repeat (16) @(posedge clk);
        resetn <= 1'b1;
        #1 cmp8({2'b00, sample_cnt}, 8'h00);
        rd(CFG_TWO_ADDR, CFG_TWO_RESET);
        repeat (2) @(posedge clk);
        tally_and_finish();
    end
endmodule : sample_buffer_flush_watermark_ctrl_tb
